/* File: hdl/pvh_voice_core.sv */
// Functional notes
// - control write bit 6 high sets channel page, low sets wave page.
// - channel page 0..7 picks channel 1..8 for parameter writes.
// - wave page top bit picks memory, low three bits pick 4K page.
// - memory one or two select strobe follows the addressed memory.
// - every voice parameter byte is stored separately per channel.
// - channel start loads address with start page high, zero low.
// - stop marker reloads address from loop bytes and fetches again.
// - step high adds per sample, bit 7 worth 16, bit 0 one eighth.
// - step low extends increment from two to minus 4 down to minus 11.
// - stereo weight upper nibble is right, lower nibble left coefficient.
// - run mask bit 0 runs channel 1 through bit 7 channel 8.
// - run mask only counts while global play bit is set.
// - no wave reads while playing; long host writes still accepted.
// - parameters write-only; wave memory free to host when stopped.
// - outputs carry delta magnitude and rise or fall direction.
// - control bit 7 starts and stops playback.
// - control byte is write-only at offset 0007H.
// - host window from 1000H maps 4K of wave memory by wave page.
`timescale 1ns/1ps
`include "pvh_regs.svh"

module pvh_voice_core #(
  parameter int SAMPLE_CYCLES = `PVH_SAMPLE_CYCLES,
  parameter int FIFO_DEPTH    = `PVH_FIFO_DEPTH
)(
  input wire logic         ref_clk,
  input wire logic         reset,
  input wire logic [12:0]  host_addr,
  input wire logic [7:0]   host_data_in,
  output logic [7:0]       host_data_out,
  output logic             host_data_oe,
  input wire logic         host_cs_n,
  input wire logic         host_rd_n,
  input wire logic         host_wr_n,
  output logic [14:0]      mem_addr,
  output logic [7:0]       mem_data_out,
  output logic             mem_data_oe,
  input wire logic [7:0]   mem_data_in,
  output logic             mem_oe_n,
  output logic             mem_we_n,
  output logic             mem_one_select_n,
  output logic             mem_two_select_n,
  output pvh_pkg::pvh_eng_t engine_state,
  input wire logic         dac_ready,
  output logic [9:0]       left_delta_count,
  output logic             left_up,
  output logic [9:0]       right_delta_count,
  output logic             right_up,
  output logic             dac_strobe
);
  import pvh_pkg::*;

  localparam int NCH = `PVH_NUM_CHANNELS;

  typedef struct packed {
    logic [NCH-1:0][7:0]  envelope_level;
    logic [NCH-1:0][7:0]  stereo_weights;
    logic [NCH-1:0][7:0]  step_low;
    logic [NCH-1:0][7:0]  step_high;
    logic [NCH-1:0][7:0]  loop_low;
    logic [NCH-1:0][7:0]  loop_high;
    logic [NCH-1:0][7:0]  start_page;
    pvh_acc_t [NCH-1:0]   acc;
    logic                 play;
    logic [2:0]           channel_page;
    logic [3:0]           wave_page;
    logic [NCH-1:0]       run_mask;
    logic [NCH-1:0]       prev_active;
    logic                 wr_idle;
    logic [15:0]          tick_cnt;
    logic                 tick_pend;
    pvh_eng_t             eng;
    logic [2:0]           ch;
    logic                 refetched;
    logic signed [15:0]   mix_l;
    logic signed [15:0]   mix_r;
    logic                 hw_pend;
    logic [14:0]          hw_addr;
    logic                 hw_mem2;
    logic [7:0]           hw_data;
    logic [14:0]          mem_addr;
    logic                 mem_one_n;
    logic                 mem_two_n;
    logic                 mem_oe_n;
    logic                 mem_we_n;
    logic [7:0]           mem_dout;
    logic                 mem_doe;
    logic [7:0]           host_dout;
    logic                 host_doe;
    logic                 push_valid;
    logic [31:0]          push_data;
  } pvh_core_t;

  pvh_core_t          st;
  pvh_core_t          next_st;
  logic [NCH-1:0]     act;
  logic               wr_hit;
  logic               wave_hit;
  logic               do_write;
  logic               adv;
  logic [7:0]         smp;

  pvh_stream_if #(.WIDTH(`PVH_FIFO_WIDTH)) mix_if ();
  pvh_stream_if #(.WIDTH(`PVH_FIFO_WIDTH)) dac_if ();

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // sign-magnitude sample scaled by envelope and a 4-bit side weight
  function automatic logic signed [15:0] pvh_term(input logic [7:0] s, input logic [7:0] env,
                                                  input logic [3:0] w);
    logic [18:0] p;
    logic [15:0] m;
    p = s[6:0] * env * w;
    m = {5'h00, p[18:8]};
    pvh_term = s[7] ? $signed(16'(-m)) : $signed(m);
  endfunction : pvh_term

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    next_st = st;
    do_write = 1'b0;
    adv = 1'b0;
    smp = mem_data_in;
    act = st.play ? st.run_mask : '0;
    wave_hit = ~host_cs_n & host_addr[`PVH_WAVE_WIN_BIT];
    wr_hit = ~host_cs_n & ~host_wr_n & st.wr_idle;
    next_st.wr_idle = host_cs_n | host_wr_n;
    next_st.mem_oe_n = 1'b1;
    next_st.mem_we_n = 1'b1;
    next_st.mem_doe = 1'b0;
    next_st.mem_one_n = 1'b1;
    next_st.mem_two_n = 1'b1;

    // wave reads only while stopped, register reads never answered
    next_st.host_doe = wave_hit & ~host_rd_n & ~st.play;
    next_st.host_dout = mem_data_in;

    case (st.eng)
      PVH_IDLE:
      begin
        if (st.hw_pend)
          do_write = 1'b1;
        else if (!st.play)
        begin
          next_st.mem_addr = {st.wave_page[2:0], host_addr[11:0]};
          if (wave_hit && !(host_rd_n && host_wr_n))
          begin
            next_st.mem_one_n = st.wave_page[3];
            next_st.mem_two_n = ~st.wave_page[3];
          end
          next_st.mem_oe_n = ~wave_hit | host_rd_n;
          next_st.mem_we_n = ~wave_hit | host_wr_n;
          next_st.mem_dout = host_data_in;
          next_st.mem_doe = wave_hit & ~host_wr_n;
        end
        else if (st.tick_pend)
        begin
          next_st.tick_pend = 1'b0;
          next_st.ch = '0;
          next_st.mix_l = '0;
          next_st.mix_r = '0;
          next_st.refetched = 1'b0;
          next_st.eng = PVH_ADDR;
        end
      end
      PVH_ADDR:
      begin
        if (st.hw_pend)
          do_write = 1'b1;
        else if (!act[st.ch] || !st.prev_active[st.ch])
          adv = 1'b1;
        else
        begin
          // select strobe from address top bit
          next_st.mem_addr = st.acc[st.ch][25:11];
          next_st.mem_one_n = st.acc[st.ch][26];
          next_st.mem_two_n = ~st.acc[st.ch][26];
          next_st.mem_oe_n = 1'b0;
          next_st.eng = PVH_DATA;
        end
      end
      PVH_DATA:
      begin
        if (smp == `PVH_STOP_MARK && !st.refetched)
        begin
          next_st.acc[st.ch] = {st.loop_high[st.ch], st.loop_low[st.ch], 11'h000};
          next_st.refetched = 1'b1;
          next_st.eng = PVH_ADDR;
        end
        else
        begin
          // a marker at the loop point too plays silence instead of spinning
          if (smp == `PVH_STOP_MARK)
            smp = 8'h00;
          // right upper nibble, left lower nibble
          next_st.mix_r = st.mix_r + pvh_term(smp, st.envelope_level[st.ch],
                                                st.stereo_weights[st.ch][7:4]);
          next_st.mix_l = st.mix_l + pvh_term(smp, st.envelope_level[st.ch],
                                                st.stereo_weights[st.ch][3:0]);
          next_st.acc[st.ch] = st.acc[st.ch] + {11'h000, st.step_high[st.ch], st.step_low[st.ch]};
          next_st.refetched = 1'b0;
          adv = 1'b1;
        end
      end
      PVH_PUSH:
      begin
        if (st.hw_pend)
          do_write = 1'b1;
        if (mix_if.ready)
        begin
          next_st.push_valid = 1'b0;
          next_st.eng = PVH_IDLE;
        end
      end
      default: next_st.eng = PVH_IDLE;
    endcase

    // set after clear: no lost tick
    if (st.tick_cnt == 16'(SAMPLE_CYCLES - 1))
    begin
      next_st.tick_cnt = '0;
      next_st.tick_pend = 1'b1;
    end
    else
      next_st.tick_cnt = st.tick_cnt + 16'h0001;

    if (adv)
    begin
      if (st.ch == 3'(NCH - 1))
      begin
        next_st.push_valid = 1'b1;
        next_st.push_data = {next_st.mix_l, next_st.mix_r};
        next_st.eng = PVH_PUSH;
      end
      else
      begin
        next_st.ch = st.ch + 3'h1;
        next_st.eng = PVH_ADDR;
      end
    end

    if (do_write)
    begin
      next_st.mem_addr = st.hw_addr;
      next_st.mem_one_n = st.hw_mem2;
      next_st.mem_two_n = ~st.hw_mem2;
      next_st.mem_we_n = 1'b0;
      next_st.mem_dout = st.hw_data;
      next_st.mem_doe = 1'b1;
      next_st.hw_pend = 1'b0;
    end

    if (wr_hit && host_addr[`PVH_WAVE_WIN_BIT] && st.play)
    begin
      // capture host write, set wins over clear
      next_st.hw_pend = 1'b1;
      next_st.hw_addr = {st.wave_page[2:0], host_addr[11:0]};
      next_st.hw_mem2 = st.wave_page[3];
      next_st.hw_data = host_data_in;
    end
    else if (wr_hit && !host_addr[`PVH_WAVE_WIN_BIT])
    begin
      case (host_addr)
        `PVH_OFS_ENVELOPE:   next_st.envelope_level[st.channel_page] = host_data_in;
        `PVH_OFS_STEREO:     next_st.stereo_weights[st.channel_page] = host_data_in;
        `PVH_OFS_STEP_LOW:   next_st.step_low[st.channel_page] = host_data_in;
        `PVH_OFS_STEP_HIGH:  next_st.step_high[st.channel_page] = host_data_in;
        `PVH_OFS_LOOP_LOW:   next_st.loop_low[st.channel_page] = host_data_in;
        `PVH_OFS_LOOP_HIGH:  next_st.loop_high[st.channel_page] = host_data_in;
        `PVH_OFS_START_PAGE: next_st.start_page[st.channel_page] = host_data_in;
        `PVH_OFS_BANK_CONTROL:
        begin
          next_st.play = host_data_in[`PVH_CTRL_PLAY_BIT];
          if (host_data_in[`PVH_CTRL_TARGET_BIT])
            next_st.channel_page = host_data_in[2:0];
          else
            next_st.wave_page = host_data_in[3:0];
        end
        `PVH_OFS_RUN_MASK:   next_st.run_mask = host_data_in;
        default: ;
      endcase
    end

    // start load wins over the step add
    for (int i = 0; i < NCH; i++)
    begin
      if (act[i] && !st.prev_active[i])
        next_st.acc[i] = {st.start_page[i], 8'h00, 11'h000};
    end
    next_st.prev_active = act;
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      st           <= '0;
      st.wr_idle   <= 1'b1;
      st.mem_oe_n  <= 1'b1;
      st.mem_we_n  <= 1'b1;
      st.mem_one_n <= 1'b1;
      st.mem_two_n <= 1'b1;
    end
    else
      st <= next_st;
  end

  // ----------------------------------------
  // outputs and output path
  // ----------------------------------------
  assign host_data_out    = st.host_dout;
  assign host_data_oe     = st.host_doe;
  assign mem_addr         = st.mem_addr;
  assign mem_data_out     = st.mem_dout;
  assign mem_data_oe      = st.mem_doe;
  assign mem_oe_n         = st.mem_oe_n;
  assign mem_we_n         = st.mem_we_n;
  assign mem_one_select_n = st.mem_one_n;
  assign mem_two_select_n = st.mem_two_n;
  assign engine_state     = st.eng;
  assign mix_if.valid     = st.push_valid;
  assign mix_if.data      = st.push_data;

  // full fifo holds the engine in push, so no frame is dropped
  pvh_fifo #(
    .WIDTH (`PVH_FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk (ref_clk),
    .reset   (reset),
    .in_s    (mix_if),
    .out_s   (dac_if)
  );

  pvh_delta_out u_delta (
    .ref_clk           (ref_clk),
    .reset             (reset),
    .in_s              (dac_if),
    .dac_ready         (dac_ready),
    .left_delta_count  (left_delta_count),
    .left_up           (left_up),
    .right_delta_count (right_delta_count),
    .right_up          (right_up),
    .dac_strobe        (dac_strobe)
  );

endmodule : pvh_voice_core

/* File: hdl/pvh_regs.svh */
`ifndef PVH_REGS_SVH
`define PVH_REGS_SVH

// ----------------------------------------
// host register offsets
// ----------------------------------------
`define PVH_OFS_ENVELOPE      13'h0000
`define PVH_OFS_STEREO        13'h0001
`define PVH_OFS_STEP_LOW      13'h0002
`define PVH_OFS_STEP_HIGH     13'h0003
`define PVH_OFS_LOOP_LOW      13'h0004
`define PVH_OFS_LOOP_HIGH     13'h0005
`define PVH_OFS_START_PAGE    13'h0006
`define PVH_OFS_BANK_CONTROL  13'h0007
`define PVH_OFS_RUN_MASK      13'h0008

// ----------------------------------------
// field positions
// ----------------------------------------
`define PVH_WAVE_WIN_BIT      12
`define PVH_CTRL_PLAY_BIT     7
`define PVH_CTRL_TARGET_BIT   6
`define PVH_FRAC_BITS         11

// ----------------------------------------
// values and timing counts
// ----------------------------------------
`define PVH_STOP_MARK         8'hFF
`define PVH_WR_MIN_CYCLES     16
`define PVH_SAMPLE_CYCLES     384
`define PVH_NUM_CHANNELS      8
`define PVH_FIFO_WIDTH        32
`define PVH_FIFO_DEPTH        32

`endif

/* File: hdl/pvh_pkg.sv */
package pvh_pkg;

  typedef enum logic [1:0] {
    PVH_IDLE = 2'b00,
    PVH_ADDR = 2'b01,
    PVH_DATA = 2'b10,
    PVH_PUSH = 2'b11
  } pvh_eng_t;

  typedef logic [26:0] pvh_acc_t;

endpackage : pvh_pkg

/* File: hdl/pvh_stream_if.sv */
`timescale 1ns/1ps

interface pvh_stream_if #(parameter int WIDTH = 32) ();
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : pvh_stream_if

/* File: hdl/pvh_fifo.sv */
`timescale 1ns/1ps

module pvh_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
)(
  input wire logic   ref_clk,
  input wire logic   reset,
  pvh_stream_if.snk  in_s,
  pvh_stream_if.src  out_s
);
  import pvh_pkg::*;

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [AW:0]                 count;
  } pvh_fifo_state_t;

  pvh_fifo_state_t st;
  pvh_fifo_state_t next_st;
  logic            push;
  logic            pop;

  // ----------------------------------------
  // handshake
  // ----------------------------------------
  assign in_s.ready  = (st.count != (AW+1)'(DEPTH));
  assign out_s.valid = (st.count != '0);
  assign out_s.data  = st.mem[st.rd_ptr];
  assign push        = in_s.valid & in_s.ready;
  assign pop         = out_s.valid & out_s.ready;

  always_comb
  begin
    next_st = st;
    if (push)
    begin
      next_st.mem[st.wr_ptr] = in_s.data;
      next_st.wr_ptr         = st.wr_ptr + 1'b1;
    end
    if (pop)
      next_st.rd_ptr = st.rd_ptr + 1'b1;
    if (push && !pop)
      next_st.count = st.count + 1'b1;
    else if (pop && !push)
      next_st.count = st.count - 1'b1;
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      st <= '0;
    else
      st <= next_st;
  end

endmodule : pvh_fifo

/* File: hdl/pvh_delta_out.sv */
`timescale 1ns/1ps

module pvh_delta_out (
  input wire logic    ref_clk,
  input wire logic    reset,
  pvh_stream_if.snk   in_s,
  input wire logic    dac_ready,
  output logic [9:0]  left_delta_count,
  output logic        left_up,
  output logic [9:0]  right_delta_count,
  output logic        right_up,
  output logic        dac_strobe
);
  import pvh_pkg::*;

  typedef struct packed {
    logic [9:0] prev_l;
    logic [9:0] prev_r;
    logic [9:0] mag_l;
    logic [9:0] mag_r;
    logic       up_l;
    logic       up_r;
    logic       strobe;
  } pvh_delta_state_t;

  pvh_delta_state_t st;
  pvh_delta_state_t next_st;
  logic [10:0]      dl;
  logic [10:0]      dr;

  // signed mix word to 10-bit offset binary for the converter
  function automatic logic [9:0] pvh_to_dac(input logic [15:0] s);
    pvh_to_dac = {~s[15], s[14:6]};
  endfunction : pvh_to_dac

  // {direction, magnitude}; equal samples keep the old direction
  function automatic logic [10:0] pvh_delta(input logic [9:0] nw, input logic [9:0] pv,
                                            input logic old_up);
    if (nw > pv)
      pvh_delta = {1'b1, 10'(nw - pv)};
    else if (nw < pv)
      pvh_delta = {1'b0, 10'(pv - nw)};
    else
      pvh_delta = {old_up, 10'h000};
  endfunction : pvh_delta

  // converter paces the drain, so a slow converter fills the fifo
  assign in_s.ready = dac_ready;

  always_comb
  begin
    next_st        = st;
    next_st.strobe = 1'b0;
    dl = pvh_delta(pvh_to_dac(in_s.data[31:16]), st.prev_l, st.up_l);
    dr = pvh_delta(pvh_to_dac(in_s.data[15:0]), st.prev_r, st.up_r);
    if (in_s.valid && dac_ready)
    begin
      next_st.mag_l  = dl[9:0];
      next_st.up_l   = dl[10];
      next_st.mag_r  = dr[9:0];
      next_st.up_r   = dr[10];
      next_st.prev_l = pvh_to_dac(in_s.data[31:16]);
      next_st.prev_r = pvh_to_dac(in_s.data[15:0]);
      next_st.strobe = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      st        <= '0;
      st.prev_l <= 10'h200;
      st.prev_r <= 10'h200;
    end
    else
      st <= next_st;
  end

  assign left_delta_count  = st.mag_l;
  assign left_up           = st.up_l;
  assign right_delta_count = st.mag_r;
  assign right_up          = st.up_r;
  assign dac_strobe        = st.strobe;

endmodule : pvh_delta_out

/* File: tb/pvh_voice_core_properties.sv */
`timescale 1ns/1ps
`include "pvh_regs.svh"

module pvh_voice_core_chk #(
  parameter int SAMPLE_CYCLES = 384,
  parameter int FIFO_DEPTH    = 32
)(
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic [12:0] host_addr,
  input wire logic [7:0]  host_data_in,
  input wire logic        host_data_oe,
  input wire logic        host_cs_n,
  input wire logic        host_rd_n,
  input wire logic        host_wr_n,
  input wire logic [14:0] mem_addr,
  input wire logic [7:0]  mem_data_out,
  input wire logic        mem_we_n,
  input wire logic        mem_one_select_n,
  input wire logic        mem_two_select_n,
  input wire logic        dac_ready,
  input wire logic        left_up,
  input wire logic        right_up,
  input wire logic        dac_strobe
);
  logic        wr_prev;
  logic        play;
  logic [3:0]  page;
  logic        wr_act;
  logic        wr_edge;
  logic        rd_act;
  logic        win;
  logic [14:0] exp_addr;

  assign wr_act   = !host_cs_n && !host_wr_n;
  assign rd_act   = !host_cs_n && !host_rd_n;
  assign wr_edge  = wr_act && !wr_prev;
  assign win      = host_addr[`PVH_WAVE_WIN_BIT];
  assign exp_addr = {page[2:0], host_addr[11:0]};

  // ----------------------------------------
  // shadow of play bit and wave page
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      wr_prev <= 1'b0;
      play    <= 1'b0;
      page    <= 4'h0;
    end
    else
    begin
      wr_prev <= wr_act;
      if (wr_edge && host_addr == `PVH_OFS_BANK_CONTROL)
      begin
        play <= host_data_in[`PVH_CTRL_PLAY_BIT];
        if (!host_data_in[`PVH_CTRL_TARGET_BIT])
          page <= host_data_in[3:0];
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sel_exclusive_a: assert property (mem_one_select_n || mem_two_select_n)
    else $error("both memory selects low");
  stop_wr_addr_a: assert property (!play && wr_act && win |=> !mem_we_n && mem_addr == $past(exp_addr))
    else $error("stopped wave write address wrong");
  stop_wr_sel_a: assert property (!play && wr_act && win |=> mem_one_select_n == $past(page[3]))
    else $error("wrong memory selected");
  stop_wr_data_a: assert property (!play && wr_act && win |=> mem_data_out == $past(host_data_in))
    else $error("stopped wave write data wrong");
  reg_rd_none_a: assert property (rd_act && !win |=> !host_data_oe)
    else $error("register read drove the bus");
  play_rd_none_a: assert property (play && rd_act |=> !host_data_oe)
    else $error("wave read answered during play");
  stop_rd_oe_a: assert property ((!play && rd_act && win) [*3] |-> host_data_oe)
    else $error("stopped wave read not answered");
  play_wr_issue_a: assert property (play && wr_edge && win |-> ##[1:4] !mem_we_n)
    else $error("wave write during play lost");
  dir_hold_a: assert property (!dac_strobe |-> $stable(left_up) && $stable(right_up))
    else $error("direction moved without strobe");
  strobe_ready_a: assert property (dac_strobe |-> $past(dac_ready))
    else $error("strobe without converter ready");

  cover property (play && wr_edge && win);
  cover property (dac_strobe && left_up);
  cover property ((!play && rd_act && win) [*3]);
endmodule : pvh_voice_core_chk

bind pvh_voice_core pvh_voice_core_chk #(.SAMPLE_CYCLES(SAMPLE_CYCLES), .FIFO_DEPTH(FIFO_DEPTH)) chk_u (
  .ref_clk(ref_clk), .reset(reset), .host_addr(host_addr), .host_data_in(host_data_in),
  .host_data_oe(host_data_oe), .host_cs_n(host_cs_n), .host_rd_n(host_rd_n), .host_wr_n(host_wr_n),
  .mem_addr(mem_addr), .mem_data_out(mem_data_out), .mem_we_n(mem_we_n),
  .mem_one_select_n(mem_one_select_n), .mem_two_select_n(mem_two_select_n), .dac_ready(dac_ready),
  .left_up(left_up), .right_up(right_up), .dac_strobe(dac_strobe));

/* File: tb/pvh_wave_mem.sv */
`timescale 1ns/1ps

module pvh_wave_mem (
  input wire logic        ref_clk,
  input wire logic [14:0] mem_addr,
  input wire logic [7:0]  mem_data_out,
  input wire logic        mem_data_oe,
  input wire logic        mem_oe_n,
  input wire logic        mem_we_n,
  input wire logic        mem_one_select_n,
  input wire logic        mem_two_select_n,
  output logic [7:0]      mem_data_in
);
  logic [7:0] bank_one [0:32767];
  logic [7:0] bank_two [0:32767];
  logic [7:0] last = 8'h00;
  logic       rd;

  assign rd = !mem_oe_n && !(mem_one_select_n && mem_two_select_n);

  // each strobe owns one 32K bank
  always @(posedge ref_clk)
  begin
    if (!mem_we_n && mem_data_oe && !mem_one_select_n)
      bank_one[mem_addr] <= mem_data_out;
    if (!mem_we_n && mem_data_oe && !mem_two_select_n)
      bank_two[mem_addr] <= mem_data_out;
    if (rd)
      last <= mem_data_in;
  end

  // released bus shows the inverse of the last value, so a stale sample is caught
  assign mem_data_in = !rd ? ~last : (!mem_one_select_n ? bank_one[mem_addr] : bank_two[mem_addr]);
endmodule : pvh_wave_mem

/* File: tb/test_pcm_voice_host_registers.sv */
`timescale 1ns/1ps
`include "pvh_regs.svh"

module test_pcm_voice_host_registers;
  import pvh_pkg::*;
  logic              ref_clk, reset, host_cs_n, host_rd_n, host_wr_n, host_data_oe, dac_ready, oe;
  logic [12:0]       host_addr;
  logic [7:0]        host_data_in, host_data_out, mem_data_out, mem_data_in, got;
  logic [14:0]       mem_addr;
  logic              mem_data_oe, mem_oe_n, mem_we_n, mem_one_select_n, mem_two_select_n;
  logic              left_up, right_up, dac_strobe;
  logic [9:0]        left_delta_count, right_delta_count;
  pvh_eng_t          eng;
  logic [11:0]       off;
  logic [7:0]        pat [16];
  logic [7:0]        prm [7] = '{8'hFF, 8'h5F, 8'h00, 8'h08, 8'h20, 8'h10, 8'h10};
  int                mismatches = 0;
  int                cmp_count = 0;
  int                strobes = 0;
  int                level_l = 512;
  int                level_r = 512;
  int                peak_l = 512;
  int                peak_r = 512;
  int unsigned       rnd;

  pvh_voice_core #(.SAMPLE_CYCLES(40)) dut_u (
    .ref_clk(ref_clk), .reset(reset), .host_addr(host_addr), .host_data_in(host_data_in),
    .host_data_out(host_data_out), .host_data_oe(host_data_oe), .host_cs_n(host_cs_n),
    .host_rd_n(host_rd_n), .host_wr_n(host_wr_n), .mem_addr(mem_addr), .mem_data_out(mem_data_out),
    .mem_data_oe(mem_data_oe), .mem_data_in(mem_data_in), .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n),
    .mem_one_select_n(mem_one_select_n), .mem_two_select_n(mem_two_select_n), .engine_state(eng),
    .dac_ready(dac_ready), .left_delta_count(left_delta_count), .left_up(left_up),
    .right_delta_count(right_delta_count), .right_up(right_up), .dac_strobe(dac_strobe));

  pvh_wave_mem mem_u (
    .ref_clk(ref_clk), .mem_addr(mem_addr), .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe),
    .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n), .mem_one_select_n(mem_one_select_n),
    .mem_two_select_n(mem_two_select_n), .mem_data_in(mem_data_in));

  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [12:0] a, input logic [7:0] d, input int hold);
    @(negedge ref_clk);
    host_addr    = a;
    host_data_in = d;
    host_cs_n    = 1'b0;
    host_wr_n    = 1'b0;
    repeat (hold) @(negedge ref_clk);
    host_cs_n = 1'b1;
    host_wr_n = 1'b1;
    host_data_in = ~d;
    @(negedge ref_clk);
  endtask : wr

  task automatic rd(input logic [12:0] a, output logic [7:0] d, output logic e);
    @(negedge ref_clk);
    host_addr = a;
    host_cs_n = 1'b0;
    host_rd_n = 1'b0;
    repeat (3) @(negedge ref_clk);
    d = host_data_out;
    e = host_data_oe;
    host_cs_n = 1'b1;
    host_rd_n = 1'b1;
    @(negedge ref_clk);
  endtask : rd

  // level one full-scale positive sample reaches on the converter for weight w
  function automatic logic [15:0] exp_level(input int w);
    return 16'(512 + ((127 * 255 * w) >> 8) / 64);
  endfunction : exp_level

  task automatic test_done();
    if (mismatches == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  // converter side: random stalls, deltas integrated back into levels
  initial
  begin
    dac_ready = 1'b0;
    @(negedge reset);
    forever
    begin
      @(negedge ref_clk);
      dac_ready = ($urandom % 4) != 0;
    end
  end

  always @(negedge ref_clk)
    if (!reset && dac_strobe === 1'b1)
    begin
      strobes++;
      level_l += left_up ? int'(left_delta_count) : -int'(left_delta_count);
      level_r += right_up ? int'(right_delta_count) : -int'(right_delta_count);
      peak_l = (level_l > peak_l) ? level_l : peak_l;
      peak_r = (level_r > peak_r) ? level_r : peak_r;
    end

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    test_done();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    host_cs_n    = 1'b1;
    host_rd_n    = 1'b1;
    host_wr_n    = 1'b1;
    host_addr    = 13'h0000;
    host_data_in = 8'h00;
    reset        = 1'b1;
    rnd          = $urandom(57024);
    off          = 12'($urandom);
    repeat (3) @(negedge ref_clk);
    reset = 1'b0;
    for (int p = 0; p < 16; p++)
    begin
      pat[p] = 8'($urandom);
      wr(`PVH_OFS_BANK_CONTROL, 8'(p), 1);
      wr({1'b1, off}, pat[p], 2);
    end
    for (int p = 0; p < 16; p++)
    begin
      wr(`PVH_OFS_BANK_CONTROL, 8'(p), 1);
      rd({1'b1, off}, got, oe);
      check({8'h00, got}, {8'h00, pat[p]});
      check({15'h0000, oe}, 16'h0001);
    end
    for (int a = 0; a < 10; a++)
    begin
      rd((a == 9) ? 13'h0800 : 13'(a), got, oe);
      check({15'h0000, oe}, 16'h0000);
    end
    wr(`PVH_OFS_BANK_CONTROL, 8'h01, 1);
    for (int i = 0; i < 65; i++)
      wr(13'h1000 + 13'(i), (i < 8) ? 8'h7F : ((i % 56) == 8) ? `PVH_STOP_MARK : 8'h00, 1);
    wr(`PVH_OFS_BANK_CONTROL, 8'h42, 1);
    for (int i = 0; i < 7; i++)
      wr(13'(i), prm[i], 1);
    wr(`PVH_OFS_BANK_CONTROL, 8'h43, 1);
    wr(`PVH_OFS_ENVELOPE, 8'h00, 1);
    wr(`PVH_OFS_RUN_MASK, 8'h04, 1);
    repeat (300) @(negedge ref_clk);
    check(16'(strobes), 16'h0000);
    wr(`PVH_OFS_RUN_MASK, 8'h00, 1);
    wr(`PVH_OFS_BANK_CONTROL, 8'h81, 1);
    repeat (400) @(negedge ref_clk);
    check({15'h0000, strobes > 0}, 16'h0001);
    check(16'(peak_l), 16'h0200);
    wr(`PVH_OFS_RUN_MASK, 8'h04, 1);
    repeat (1200) @(negedge ref_clk);
    check(16'(peak_l), exp_level(15));
    check(16'(peak_r), exp_level(5));
    check(16'(level_l), 16'h0200);
    wr(13'h1100, 8'hA5, 18);
    rd(13'h1100, got, oe);
    check({15'h0000, oe}, 16'h0000);
    wr(`PVH_OFS_BANK_CONTROL, 8'h01, 1);
    repeat (100) @(negedge ref_clk);
    strobes = 0;
    repeat (300) @(negedge ref_clk);
    check(16'(strobes), 16'h0000);
    check(16'(eng), 16'h0000);
    rd(13'h1100, got, oe);
    check({8'h00, got}, 16'h00A5);
    test_done();
  end
endmodule : test_pcm_voice_host_registers
